// *** hdl/dcs_pkg.sv ***
// Package with register map, field layout, codes and helpers of the command scaler.
package dcs_pkg;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_BCD_BIAS = 8'h04;
  localparam logic [7:0] ADDR_BCD_GAIN = 8'h08;
  localparam logic [7:0] ADDR_BIN_BIAS = 8'h0C;
  localparam logic [7:0] ADDR_BIN_GAIN = 8'h10;
  localparam logic [7:0] ADDR_TRQ = 8'h14;
  localparam logic [7:0] ADDR_TRQ_PARAM = 8'h18;
  localparam logic [7:0] ADDR_RAMP = 8'h1C;
  localparam logic [7:0] ADDR_FREQ = 8'h20;
  localparam logic [7:0] ADDR_STAT = 8'h24;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_INCR_LSB = 16;
  localparam int CFG_TSRC_LSB = 20;
  localparam int TRQ_GAIN_LSB = 16;
  localparam logic [13:0] MODE_BCD3 = 14'h0000;
  localparam logic [13:0] MODE_BIN12C = 14'h0003;
  localparam logic [13:0] MODE_BCD3C = 14'h0002;
  localparam logic [13:0] MODE_TRQ12 = 14'h0004;
  localparam logic [13:0] MODE_BCD4 = 14'h000A;
  localparam logic [13:0] MODE_BIN16 = 14'h000B;
  localparam logic [13:0] MODE_BCD4C = 14'h000C;
  localparam logic [13:0] MODE_BIN16C = 14'h000D;
  localparam logic [13:0] MODE_TRQ16 = 14'h000E;
  localparam logic [13:0] MODE_OFF = 14'h270F;
  localparam logic [16:0] FREQ_LIMIT = 17'h09C40;
  localparam logic [16:0] GAIN_DIRECT = 17'h1FFFF;
  localparam logic [16:0] FREQ_GAIN_RST = 17'h01770;
  localparam logic [16:0] RAMP_RST = 17'h01770;
  localparam logic [1:0] INCR_RST = 2'h1;
  localparam logic [9:0] MULT_10HZ = 10'h3E8;
  localparam logic [9:0] MULT_1HZ = 10'h064;
  localparam logic [9:0] MULT_100MHZ = 10'h00A;
  localparam logic [9:0] MULT_10MHZ = 10'h001;
  localparam logic signed [35:0] FULL_BCD3 = 36'sh0000003E7;
  localparam logic signed [35:0] FULL_BCD4 = 36'sh00000270F;
  localparam logic signed [35:0] FULL_BIN12 = 36'sh000000FFF;
  localparam logic signed [35:0] FULL_BIN16 = 36'sh00000FFFF;
  localparam logic signed [35:0] FULL_TRQ16 = 36'sh000007FFF;
  localparam logic signed [35:0] FULL_TRQ12 = 36'sh0000007FF;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [15:0] BCD_RADIX = 16'h000A;
  localparam logic [8:0] TRQ_LIMIT = 9'h190;
  localparam logic [13:0] TRQ_GAIN_MAX = 14'h0190;
  localparam logic [13:0] TRQ_GAIN_RST = 14'h0096;
  localparam logic [13:0] TRQ_DIRECT = 14'h270F;
  localparam logic signed [10:0] TRQ_PARAM_MAX = 11'sh190;
  localparam logic [2:0] TSRC_ANALOG = 3'h0;
  localparam logic [2:0] TSRC_PARAM = 3'h1;
  localparam logic [2:0] TSRC_LOW_GAP = 3'h2;
  localparam logic [2:0] TSRC_DIGITAL = 3'h4;
  localparam logic [2:0] TSRC_MAX = 3'h6;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_JOG = 3'b001,
    SRC_MULTI = 3'b010,
    SRC_PID = 3'b011,
    SRC_AUX = 3'b100,
    SRC_DIGITAL = 3'b101,
    SRC_MAIN = 3'b110
  } dcs_src_t;
  function automatic logic mode_bcd(input logic [13:0] m);
    return m == MODE_BCD3 || m == MODE_BCD3C || m == MODE_BCD4 || m == MODE_BCD4C;
  endfunction
  function automatic logic mode_bin(input logic [13:0] m);
    return (m != MODE_BCD3 && m <= MODE_BIN12C && m != MODE_BCD3C) ||
      m == MODE_BIN16 || m == MODE_BIN16C;
  endfunction
  function automatic logic mode_comp(input logic [13:0] m);
    return m == MODE_BCD3C || m == MODE_BIN12C || m == MODE_BCD4C || m == MODE_BIN16C;
  endfunction
  function automatic logic mode_valid(input logic [13:0] m);
    return m <= MODE_TRQ12 || (m >= MODE_BCD4 && m <= MODE_TRQ16) || m == MODE_OFF;
  endfunction
endpackage

// *** hdl/dcs_bcd_decode.sv ***
// BCD digit decoder with a rejection flag for out-of-range digits.
`timescale 1ns/10ps
`default_nettype none
module dcs_bcd_decode #(
  parameter int DIGITS = 4
) (
  input wire logic [15:0] word,
  input wire logic four_digit,
  output logic [15:0] value,
  output logic invalid
);
  logic [DIGITS-1:0] bad;
  logic [DIGITS-1:0] used;
  genvar i;
  generate
    for (i = 0; i < DIGITS; i++) begin : g_digit
      assign used[i] = (i < DIGITS - 1) || four_digit;
      assign bad[i] = used[i] && (word[4*i +: 4] > dcs_pkg::BCD_DIGIT_MAX);
    end
  endgenerate
  always_comb begin
    value = '0;
    for (int k = DIGITS - 1; k >= 0; k--) begin
      if (used[k]) begin
        value = 16'(value * dcs_pkg::BCD_RADIX + 16'(word[4*k +: 4]));
      end
    end
    invalid = |bad;
  end
endmodule
`default_nettype wire

// *** hdl/dcs_torque_map.sv ***
// Sign and magnitude torque word to a signed torque percentage.
`timescale 1ns/10ps
`default_nettype none
module dcs_torque_map (
  input wire logic [15:0] word,
  input wire logic wide,
  input wire logic [8:0] bias,
  input wire logic [13:0] gain,
  output logic signed [10:0] torque
);
  logic [14:0] mag;
  logic sign;
  logic signed [35:0] span;
  logic signed [35:0] amt;
  always_comb begin
    mag = wide ? word[14:0] : {4'h0, word[10:0]};
    sign = wide ? word[15] : word[11];
    span = 36'($signed({1'b0, gain})) - 36'($signed({1'b0, bias}));
    if (gain == dcs_pkg::TRQ_DIRECT) begin
      amt = (mag > 15'(dcs_pkg::TRQ_LIMIT)) ? 36'(dcs_pkg::TRQ_LIMIT) : 36'(mag);
    end else begin
      // Bias is widened as signed so a gain below bias still divides as a signed value.
      amt = 36'($signed({1'b0, bias})) + span * 36'($signed({1'b0, mag})) /
        (wide ? dcs_pkg::FULL_TRQ16 : dcs_pkg::FULL_TRQ12);
    end
    torque = sign ? -11'(amt) : 11'(amt);
  end
endmodule
`default_nettype wire

// *** hdl/dcs_scaler.sv ***
// Digital command scaler: pin word to frequency and torque commands, AHB-Lite registers.
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module dcs_scaler (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] digital_command_lines,
  input wire logic jog_request,
  input wire logic speed_select_high,
  input wire logic speed_select_mid,
  input wire logic speed_select_low,
  input wire logic pid_request,
  input wire logic aux_analog_select,
  input wire logic [16:0] jog_freq,
  input wire logic [16:0] multi_speed_freq,
  input wire logic [16:0] pid_freq,
  input wire logic [16:0] aux_analog_freq,
  input wire logic [16:0] main_analog_freq,
  input wire logic signed [17:0] analog_comp,
  input wire logic signed [10:0] analog_torque,
  output logic [31:0] freq_cmd,
  output logic [2:0] freq_src,
  output logic [16:0] ramp_ref_freq,
  output logic signed [10:0] torque_cmd,
  output logic torque_active
);
  logic [21:0] meta_q;
  logic [21:0] sync_q;
  logic dp_wr_q;
  logic [7:0] dp_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [13:0] mode_q;
  logic [1:0] incr_q;
  logic [2:0] tsrc_q;
  logic [16:0] bcd_bias_q;
  logic [16:0] bcd_gain_q;
  logic [16:0] bin_bias_q;
  logic [16:0] bin_gain_q;
  logic [8:0] trq_bias_q;
  logic [13:0] trq_gain_q;
  logic signed [10:0] trq_param_q;
  logic [16:0] ramp_q;
  logic [15:0] val_q;
  logic prev_bcd_q;
  logic bcd_rej_q;
  logic [31:0] freq_cmd_q;
  dcs_pkg::dcs_src_t freq_src_q;
  dcs_pkg::dcs_src_t src_d;
  logic signed [10:0] torque_cmd_q;
  logic torque_active_q;
  logic [15:0] lines;
  logic [15:0] lines_m;
  logic jog_s;
  logic multi_s;
  logic pid_s;
  logic aux_s;
  logic narrow;
  logic wide;
  logic is_bcd;
  logic is_bin;
  logic comp_en;
  logic dig_valid;
  logic trq_en;
  logic [15:0] bcd_val;
  logic bcd_bad;
  logic [15:0] val_sel;
  logic [16:0] bias_sel;
  logic [16:0] gain_sel;
  logic direct;
  logic [9:0] mult;
  logic signed [35:0] span;
  logic signed [35:0] prod;
  logic signed [35:0] quot;
  logic signed [35:0] freq_dig;
  logic signed [35:0] freq_comp;
  logic [31:0] freq_d;
  logic signed [10:0] torque_dig;
  logic signed [10:0] torque_d;
  logic [14:0] trq_mag;

  // Pins come from outside the clock domain, so every line passes two flops first.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {aux_analog_select, pid_request, speed_select_low, speed_select_mid,
        speed_select_high, jog_request, digital_command_lines};
      sync_q <= meta_q;
    end
  end
  assign lines = sync_q[15:0];
  assign jog_s = sync_q[16];
  assign multi_s = |sync_q[19:17];
  assign pid_s = sync_q[20];
  assign aux_s = sync_q[21];

  // Zero wait states: read data is captured in the address phase.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_comb begin
    case (haddr[7:0])
      dcs_pkg::ADDR_CFG: rdata_d = 32'({tsrc_q, 2'h0, incr_q, 2'h0, mode_q});
      dcs_pkg::ADDR_BCD_BIAS: rdata_d = 32'(bcd_bias_q);
      dcs_pkg::ADDR_BCD_GAIN: rdata_d = 32'(bcd_gain_q);
      dcs_pkg::ADDR_BIN_BIAS: rdata_d = 32'(bin_bias_q);
      dcs_pkg::ADDR_BIN_GAIN: rdata_d = 32'(bin_gain_q);
      dcs_pkg::ADDR_TRQ: rdata_d = 32'({trq_gain_q, 7'h00, trq_bias_q});
      dcs_pkg::ADDR_TRQ_PARAM: rdata_d = 32'(trq_param_q);
      dcs_pkg::ADDR_RAMP: rdata_d = 32'(ramp_q);
      dcs_pkg::ADDR_FREQ: rdata_d = freq_cmd_q;
      dcs_pkg::ADDR_STAT: rdata_d = {5'h00, torque_cmd_q, 10'h000, torque_active_q,
        bcd_rej_q, dig_valid, freq_src_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else if (hready) begin
      dp_wr_q <= hsel && htrans[1] && hwrite;
      dp_addr_q <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Except for the ramp, settings outside their range are dropped so the previous value stays in force.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= dcs_pkg::MODE_OFF;
      incr_q <= dcs_pkg::INCR_RST;
      tsrc_q <= dcs_pkg::TSRC_ANALOG;
      bcd_bias_q <= '0;
      bin_bias_q <= '0;
      bcd_gain_q <= dcs_pkg::FREQ_GAIN_RST;
      bin_gain_q <= dcs_pkg::FREQ_GAIN_RST;
      trq_bias_q <= '0;
      trq_gain_q <= dcs_pkg::TRQ_GAIN_RST;
      trq_param_q <= '0;
      ramp_q <= dcs_pkg::RAMP_RST;
    end else if (dp_wr_q) begin
      case (dp_addr_q)
        dcs_pkg::ADDR_CFG: begin
          if (dcs_pkg::mode_valid(hwdata[dcs_pkg::CFG_MODE_LSB +: 14])) begin
            mode_q <= hwdata[dcs_pkg::CFG_MODE_LSB +: 14];
          end
          incr_q <= hwdata[dcs_pkg::CFG_INCR_LSB +: 2];
          if (hwdata[dcs_pkg::CFG_TSRC_LSB +: 3] != dcs_pkg::TSRC_LOW_GAP &&
              hwdata[dcs_pkg::CFG_TSRC_LSB +: 3] <= dcs_pkg::TSRC_MAX) begin
            tsrc_q <= hwdata[dcs_pkg::CFG_TSRC_LSB +: 3];
          end
        end
        dcs_pkg::ADDR_BCD_BIAS: if (hwdata[16:0] <= dcs_pkg::FREQ_LIMIT) begin
          bcd_bias_q <= hwdata[16:0];
        end
        dcs_pkg::ADDR_BCD_GAIN: if (hwdata[16:0] <= dcs_pkg::FREQ_LIMIT ||
            hwdata[16:0] == dcs_pkg::GAIN_DIRECT) begin
          bcd_gain_q <= hwdata[16:0];
        end
        dcs_pkg::ADDR_BIN_BIAS: if (hwdata[16:0] <= dcs_pkg::FREQ_LIMIT) begin
          bin_bias_q <= hwdata[16:0];
        end
        dcs_pkg::ADDR_BIN_GAIN: if (hwdata[16:0] <= dcs_pkg::FREQ_LIMIT ||
            hwdata[16:0] == dcs_pkg::GAIN_DIRECT) begin
          bin_gain_q <= hwdata[16:0];
        end
        dcs_pkg::ADDR_TRQ: begin
          if (hwdata[8:0] <= dcs_pkg::TRQ_LIMIT) begin
            trq_bias_q <= hwdata[8:0];
          end
          if (hwdata[dcs_pkg::TRQ_GAIN_LSB +: 14] <= dcs_pkg::TRQ_GAIN_MAX ||
              hwdata[dcs_pkg::TRQ_GAIN_LSB +: 14] == dcs_pkg::TRQ_DIRECT) begin
            trq_gain_q <= hwdata[dcs_pkg::TRQ_GAIN_LSB +: 14];
          end
        end
        dcs_pkg::ADDR_TRQ_PARAM: if ($signed(hwdata[10:0]) <= dcs_pkg::TRQ_PARAM_MAX &&
            $signed(hwdata[10:0]) >= -dcs_pkg::TRQ_PARAM_MAX) begin
          trq_param_q <= $signed(hwdata[10:0]);
        end
        dcs_pkg::ADDR_RAMP: ramp_q <= hwdata[16:0];
        default: ;
      endcase
    end
  end

  assign narrow = mode_q <= dcs_pkg::MODE_BIN12C;
  assign wide = mode_q >= dcs_pkg::MODE_BCD4 && mode_q != dcs_pkg::MODE_OFF;
  assign is_bcd = dcs_pkg::mode_bcd(mode_q);
  assign is_bin = dcs_pkg::mode_bin(mode_q);
  assign comp_en = dcs_pkg::mode_comp(mode_q);
  assign dig_valid = is_bcd || is_bin;
  assign trq_en = tsrc_q == dcs_pkg::TSRC_DIGITAL &&
    (mode_q == dcs_pkg::MODE_TRQ12 || mode_q == dcs_pkg::MODE_TRQ16);
  assign lines_m = narrow ? {4'h0, lines[11:0]} : lines;
  assign trq_mag = wide ? lines_m[14:0] : {4'h0, lines_m[10:0]};

  dcs_bcd_decode #(
    .DIGITS(4)
  ) u_bcd (
    .word(lines_m),
    .four_digit(wide),
    .value(bcd_val),
    .invalid(bcd_bad)
  );

  dcs_torque_map u_trq (
    .word(lines_m),
    .wide(wide),
    .bias(trq_bias_q),
    .gain(trq_gain_q),
    .torque(torque_dig)
  );

  // A rejected BCD word keeps the last good value, unless a non-BCD mode was in force just before.
  always_comb begin
    if (is_bcd && bcd_bad) begin
      val_sel = prev_bcd_q ? val_q : 16'h0000;
    end else begin
      val_sel = is_bcd ? bcd_val : lines_m;
    end
  end

  always_comb begin
    bias_sel = is_bcd ? bcd_bias_q : bin_bias_q;
    gain_sel = is_bcd ? bcd_gain_q : bin_gain_q;
    direct = gain_sel == dcs_pkg::GAIN_DIRECT;
    case (incr_q)
      2'h0: mult = dcs_pkg::MULT_10HZ;
      2'h1: mult = dcs_pkg::MULT_1HZ;
      2'h2: mult = dcs_pkg::MULT_100MHZ;
      default: mult = dcs_pkg::MULT_10MHZ;
    endcase
    span = 36'($signed({1'b0, gain_sel})) - 36'($signed({1'b0, bias_sel}));
    prod = span * 36'($signed({1'b0, val_sel}));
    case ({wide, is_bin})
      2'b00: quot = prod / dcs_pkg::FULL_BCD3;
      2'b01: quot = prod / dcs_pkg::FULL_BIN12;
      2'b10: quot = prod / dcs_pkg::FULL_BCD4;
      default: quot = prod / dcs_pkg::FULL_BIN16;
    endcase
    if (direct) begin
      freq_dig = 36'(val_sel) * 36'(mult);
    end else begin
      freq_dig = 36'(bias_sel) + quot;
    end
    freq_comp = comp_en ? freq_dig + 36'(analog_comp) : freq_dig;
    freq_d = (freq_comp < 0) ? 32'h0000_0000 : freq_comp[31:0];
  end

  // Fixed priority; the main analog input only wins while no digital mode is valid.
  always_comb begin
    if (jog_s) begin
      src_d = dcs_pkg::SRC_JOG;
    end else if (multi_s) begin
      src_d = dcs_pkg::SRC_MULTI;
    end else if (pid_s) begin
      src_d = dcs_pkg::SRC_PID;
    end else if (aux_s) begin
      src_d = dcs_pkg::SRC_AUX;
    end else if (dig_valid) begin
      src_d = dcs_pkg::SRC_DIGITAL;
    end else begin
      src_d = dcs_pkg::SRC_MAIN;
    end
  end

  always_comb begin
    case (tsrc_q)
      dcs_pkg::TSRC_ANALOG: torque_d = analog_torque;
      dcs_pkg::TSRC_PARAM: torque_d = trq_param_q;
      dcs_pkg::TSRC_DIGITAL: torque_d = trq_en ? torque_dig : 11'sh000;
      default: torque_d = 11'sh000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      val_q <= 16'h0000;
      prev_bcd_q <= 1'b0;
      bcd_rej_q <= 1'b0;
    end else begin
      val_q <= val_sel;
      prev_bcd_q <= is_bcd;
      bcd_rej_q <= is_bcd && bcd_bad;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freq_cmd_q <= 32'h0000_0000;
      freq_src_q <= dcs_pkg::SRC_NONE;
      torque_cmd_q <= 11'sh000;
      torque_active_q <= 1'b0;
    end else begin
      freq_src_q <= src_d;
      case (src_d)
        dcs_pkg::SRC_JOG: freq_cmd_q <= 32'(jog_freq);
        dcs_pkg::SRC_MULTI: freq_cmd_q <= 32'(multi_speed_freq);
        dcs_pkg::SRC_PID: freq_cmd_q <= 32'(pid_freq);
        dcs_pkg::SRC_AUX: freq_cmd_q <= 32'(aux_analog_freq);
        dcs_pkg::SRC_DIGITAL: freq_cmd_q <= freq_d;
        default: freq_cmd_q <= 32'(main_analog_freq);
      endcase
      torque_cmd_q <= torque_d;
      torque_active_q <= trq_en;
    end
  end

  assign freq_cmd = freq_cmd_q;
  assign freq_src = freq_src_q;
  assign ramp_ref_freq = ramp_q;
  assign torque_cmd = torque_cmd_q;
  assign torque_active = torque_active_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_bin_then_bad;
    !is_bcd ##1 (is_bcd && bcd_bad);
  endsequence
  property p_direct_incr;
    src_d == dcs_pkg::SRC_DIGITAL && direct && !comp_en && incr_q == 2'h0 |=>
      freq_cmd_q == 32'($past(val_sel)) * 32'(dcs_pkg::MULT_10HZ);
  endproperty
  a_direct_incr: assert property (p_direct_incr) else $error("direct frequency wrong");
  property p_scaled_zero;
    src_d == dcs_pkg::SRC_DIGITAL && !direct && !comp_en && val_sel == 16'h0000 |=>
      freq_cmd_q == 32'($past(bias_sel));
  endproperty
  a_scaled_zero: assert property (p_scaled_zero) else $error("zero input not at bias");
  property p_bcd_hold;
    is_bcd && bcd_bad && prev_bcd_q |=> val_q == $past(val_q);
  endproperty
  a_bcd_hold: assert property (p_bcd_hold) else $error("rejected BCD word taken");
  property p_bcd_zero;
    s_bin_then_bad |=> val_q == 16'h0000;
  endproperty
  a_bcd_zero: assert property (p_bcd_zero) else $error("value not zeroed");
  property p_jog;
    jog_s |=> freq_src_q == dcs_pkg::SRC_JOG && freq_cmd_q == 32'($past(jog_freq));
  endproperty
  a_jog: assert property (p_jog) else $error("jog not highest priority");
  property p_main_off;
    dig_valid |=> freq_src_q != dcs_pkg::SRC_MAIN;
  endproperty
  a_main_off: assert property (p_main_off) else $error("main analog used");
  property p_trq_active;
    1'b1 |=> torque_active_q == $past(trq_en);
  endproperty
  a_trq_active: assert property (p_trq_active) else $error("torque enable wrong");
  property p_trq_clamp;
    trq_en && trq_gain_q == dcs_pkg::TRQ_DIRECT && trq_mag > 15'(dcs_pkg::TRQ_LIMIT) |=>
      (torque_cmd_q == dcs_pkg::TRQ_PARAM_MAX || torque_cmd_q == -dcs_pkg::TRQ_PARAM_MAX);
  endproperty
  a_trq_clamp: assert property (p_trq_clamp) else $error("torque not clamped");
  property p_trq_param;
    tsrc_q == dcs_pkg::TSRC_PARAM ##1 tsrc_q == dcs_pkg::TSRC_PARAM |->
      torque_cmd_q == $past(trq_param_q);
  endproperty
  a_trq_param: assert property (p_trq_param) else $error("parameter torque wrong");
  property p_gain_reject;
    dp_wr_q && dp_addr_q == dcs_pkg::ADDR_TRQ &&
      hwdata[dcs_pkg::TRQ_GAIN_LSB +: 14] > dcs_pkg::TRQ_GAIN_MAX &&
      hwdata[dcs_pkg::TRQ_GAIN_LSB +: 14] != dcs_pkg::TRQ_DIRECT |=>
      trq_gain_q == $past(trq_gain_q);
  endproperty
  a_gain_reject: assert property (p_gain_reject) else $error("bad gain stored");
endmodule
`default_nettype wire

// *** sim/dcs_cmd_source.sv ***
// Model of the external controller that drives the parallel command lines.
`timescale 1ns/10ps
`default_nettype none
module dcs_cmd_source #(
  parameter int SETTLE_NS = 3
) (
  input wire logic [15:0] word,
  input wire logic manual,
  output logic [15:0] lines
);
  // Lines move a little after a decision, so they never change on a clock edge.
  always @(word or manual) begin
    lines <= #SETTLE_NS (manual ? 16'h0000 : word);
  end
endmodule
`default_nettype wire

// *** sim/digital_command_scaler_tb.sv ***
// Self-checking testbench of the digital command scaler.
`timescale 1ns/10ps
`default_nettype none
module digital_command_scaler_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] word = 16'h0;
  logic manual = 1'b0;
  logic [5:0] sw = 6'h00;
  logic [16:0] fq [0:4] = '{17'h0006F, 17'h000DE, 17'h0014D, 17'h001BC, 17'h00309};
  logic signed [17:0] comp = 18'sh00000;
  logic signed [10:0] atrq = 11'sh025;
  logic hreadyout, hresp, torque_active;
  logic [31:0] hrdata, freq_cmd, r;
  logic [2:0] freq_src;
  logic [16:0] ramp_ref_freq;
  logic signed [10:0] torque_cmd;
  logic [15:0] lines;
  logic [31:0] e256 [0:3] = '{32'h3E800, 32'h6400, 32'hA00, 32'h100};
  int err_count = 0;
  int n_tests = 0;
  always #5 core_clk = ~core_clk;
  dcs_cmd_source u_src (.word(word), .manual(manual), .lines(lines));
  dcs_scaler u_dut (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .digital_command_lines(lines), .jog_request(sw[5]), .speed_select_high(sw[4]),
    .speed_select_mid(sw[3]), .speed_select_low(sw[2]), .pid_request(sw[1]),
    .aux_analog_select(sw[0]), .jog_freq(fq[0]), .multi_speed_freq(fq[1]),
    .pid_freq(fq[2]), .aux_analog_freq(fq[3]), .main_analog_freq(fq[4]),
    .analog_comp(comp), .analog_torque(atrq), .freq_cmd(freq_cmd), .freq_src(freq_src),
    .ramp_ref_freq(ramp_ref_freq), .torque_cmd(torque_cmd), .torque_active(torque_active)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask
  // Pin words pass two sync flops and a register, so five edges leave margin.
  task automatic put(input logic [15:0] w);
    word <= w;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic cfg(input logic [31:0] d, input logic [15:0] w, input logic [31:0] e);
    bus(1'b1, 8'h00, d);
    put(w);
    chk(freq_cmd, e);
  endtask
  task automatic t_regs();
    bus(1'b0, 8'h00, 32'h0);
    chk(r, 32'h0001270F);
    bus(1'b1, 8'h14, 32'h01F40000);
    bus(1'b0, 8'h14, 32'h0);
    chk(r, 32'h00960000);
    bus(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0);
    chk({15'h0, ramp_ref_freq}, 32'h1770);
    bus(1'b1, 8'h1C, 32'h2710);
    bus(1'b0, 8'h1C, 32'h0);
    chk(r, 32'h2710);
    chk({15'h0, ramp_ref_freq}, 32'h2710);
  endtask
  task automatic t_freq();
    bus(1'b1, 8'h08, 32'h1FFFF);
    bus(1'b1, 8'h10, 32'h1FFFF);
    for (int i = 0; i < 4; i++) cfg({14'h0, i[1:0], 16'h000B}, 16'h0100, e256[i]);
    chk({29'h0, freq_src}, 32'h5);
    bus(1'b1, 8'h10, 32'h01770);
    for (int i = 0; i < 4; i++) cfg({14'h0, i[1:0], 16'h000B}, 16'hFFFF, 32'h1770);
    bus(1'b1, 8'h10, 32'h1FFFF);
    cfg(32'h00030001, 16'hF005, 32'h5);
    cfg(32'h00030000, 16'h0999, 32'h3E7);
    cfg(32'h0003000A, 16'h1111, 32'h457);
    put(16'h111A);
    chk(freq_cmd, 32'h457);
    cfg(32'h0003000B, 16'h001A, 32'h1A);
    cfg(32'h0003000A, 16'h001A, 32'h0);
    comp <= 18'sh00064;
    cfg(32'h0003000D, 16'h0005, 32'h69);
    cfg(32'h0003000B, 16'h0005, 32'h5);
    manual <= 1'b1;
    cfg(32'h00030002, 16'h0123, 32'h64);
    manual <= 1'b0;
    comp <= 18'sh00000;
  endtask
  task automatic tq(input logic [31:0] d, input logic [15:0] w, input logic [10:0] e);
    bus(1'b1, 8'h00, d);
    put(w);
    chk({21'h0, torque_cmd}, {21'h0, e});
  endtask
  task automatic t_torque();
    tq(32'h0041000E, 16'h7FFF, 11'h096);
    chk({31'h0, torque_active}, 32'h1);
    tq(32'h0001000E, 16'h7FFF, 11'h025);
    chk({31'h0, torque_active}, 32'h0);
    bus(1'b1, 8'h18, 32'h000007FB);
    tq(32'h0011000E, 16'h7FFF, 11'h7FB);
    bus(1'b1, 8'h14, 32'h270F0000);
    tq(32'h0041000E, 16'h8200, 11'h670);
    tq(32'h0041000E, 16'h0019, 11'h019);
    tq(32'h00410004, 16'h0864, 11'h79C);
  endtask
  task automatic prio(input logic [5:0] s, input logic [2:0] src, input logic [16:0] f);
    sw <= s;
    put(16'h0005);
    chk({29'h0, freq_src}, {29'h0, src});
    chk(freq_cmd, {15'h0, f});
  endtask
  task automatic t_prio();
    bus(1'b1, 8'h00, 32'h0003000B);
    prio(6'h3F, 3'h1, fq[0]);
    prio(6'h1F, 3'h2, fq[1]);
    prio(6'h03, 3'h3, fq[2]);
    prio(6'h01, 3'h4, fq[3]);
    prio(6'h00, 3'h5, 17'h00005);
    bus(1'b1, 8'h00, 32'h0001270F);
    prio(6'h00, 3'h6, fq[4]);
    bus(1'b0, 8'h20, 32'h0);
    chk(r, {15'h0, fq[4]});
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_freq();
    t_torque();
    t_prio();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
